/* logic/pfm_regs.svh */
`ifndef PFM_REGS_SVH
`define PFM_REGS_SVH

// ==========================================================
// Register offsets
`define PFM_OFF_CTRL 8'h00
`define PFM_OFF_LIMITS 8'h04
`define PFM_OFF_STATUS 8'h08
`define PFM_OFF_SETPOINT 8'h0C
`define PFM_OFF_RATED 8'h10

// ==========================================================
// Field positions
`define PFM_CTRL_EN_BIT 0
`define PFM_CTRL_TRK_EN_BIT 1
`define PFM_CTRL_LATCH_LSB 2
`define PFM_LIM_OC_LSB 0
`define PFM_LIM_OV_LSB 4
`define PFM_LIM_UV_LSB 6
`define PFM_LIM_PG_BIT 8
`define PFM_ST_WARN_BIT 5
`define PFM_ST_PG_BIT 6
`define PFM_ST_ON_BIT 7
`define PFM_ST_OTHOLD_BIT 8
`define PFM_ST_LATCH_BIT 9

// ==========================================================
// Reset values
`define PFM_CTRL_RST 16'h0001
`define PFM_LIMITS_RST 16'h002A
`define PFM_SETPOINT_RST 16'h09C4
`define PFM_RATED_RST 16'h2710

// ==========================================================
// Limits in percent, millivolts and degrees C
`define PFM_PCT_FULL 8'h64
`define PFM_OC_BASE 8'h32
`define PFM_OC_INC 8'h0A
`define PFM_OC_MAXSTEP 4'hA
`define PFM_OV_BASE 8'h6E
`define PFM_OV_INC 8'h0A
`define PFM_OV_MAXSTEP 4'h2
`define PFM_UV_BASE 8'h4B
`define PFM_UV_INC 8'h05
`define PFM_UV_MAXSTEP 4'h2
`define PFM_PG_LO_BASE 8'h5A
`define PFM_PG_INC 8'h05
`define PFM_PG_MAXSTEP 4'h1
`define PFM_PG_HI_PCT 8'h6E
`define PFM_OV_FLOOR_MV 16'h03E8
`define PFM_TRK_LIMIT_MV 16'h00FA
`define PFM_OT_TRIP_C 10'sh082
`define PFM_OT_RESTART_C 10'sh078
`define PFM_WARN_C 10'sh078
`define PFM_WARN_HYST_C 10'sh003

// ==========================================================
// Timing
`define PFM_CLK_PERIOD_NS 4
`define PFM_FILTER_NS 6000
`define PFM_FILTER_CYC ((`PFM_FILTER_NS + `PFM_CLK_PERIOD_NS - 1) / `PFM_CLK_PERIOD_NS)
`define PFM_RETRY_MS 130
`define PFM_RETRY_CYC (`PFM_RETRY_MS * 1000000 / `PFM_CLK_PERIOD_NS)

`endif

/* logic/pfm_pkg.sv */
package pfm_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pfm_bus_req_t;

  typedef struct packed {
    logic [15:0] vout_mv;
    logic [15:0] iout_ma;
    logic [15:0] ramp_ref_mv;
    logic signed [9:0] temp_c;
    logic ramping;
  } pfm_meas_t;

  typedef struct packed {
    logic trk;
    logic ot;
    logic uv;
    logic ov;
    logic oc;
  } pfm_fault_t;

  typedef enum logic [3:0] {
    PFM_ST_OFF = 4'b0001,
    PFM_ST_RUN = 4'b0010,
    PFM_ST_RETRY = 4'b0100,
    PFM_ST_LATCH = 4'b1000
  } pfm_state_t;

endpackage

/* logic/pfm_sync3.sv */
`timescale 1ns/1ns
module pfm_sync3 (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_async,
  output logic o_level
);
  logic ff1_reg;
  logic ff2_reg;
  logic ff3_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ff1_reg <= 1'b0;
      ff2_reg <= 1'b0;
      ff3_reg <= 1'b0;
    end else begin
      ff1_reg <= i_async;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
    end
  end

  // A change counts only once the last two stages agree
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_level <= 1'b0;
    end else if (ff2_reg == ff3_reg) begin
      o_level <= ff3_reg;
    end
  end
endmodule

/* logic/pfm_delay_filter.sv */
`timescale 1ns/1ns
module pfm_delay_filter #(
  parameter int W = 6,
  parameter int N = 1500
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_raw,
  output logic [W-1:0] o_q
);
  localparam int CW = $clog2(N + 1);
  logic [CW-1:0] cnt_reg [W];

  // Each output follows its input only after N steady cycles of difference
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_q <= '0;
      for (int k = 0; k < W; k++) begin
        cnt_reg[k] <= '0;
      end
    end else begin
      for (int k = 0; k < W; k++) begin
        if (i_raw[k] == o_q[k]) begin
          cnt_reg[k] <= '0;
        end else if (cnt_reg[k] == CW'(N - 1)) begin
          o_q[k] <= i_raw[k];
          cnt_reg[k] <= '0;
        end else begin
          cnt_reg[k] <= cnt_reg[k] + CW'(1);
        end
      end
    end
  end

  for (genvar g = 0; g < W; g++) begin : g_chk
    chk_filter_delay_len: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      $changed(o_q[g]) |-> ($past(cnt_reg[g]) == CW'(N - 1)) && ($past(i_raw[g]) == o_q[g]))
      else $error("filtered output changed before the qualifying delay");
  end
endmodule

/* logic/pfm_fault_manager.sv */
// Behaviour
// - Overcurrent limit 50..150 percent rated in 11 steps, default 150, retry or latch.
// - Overvoltage limit 110..130 percent setpoint in 10 percent steps, default 130.
// - Overvoltage trip level never below 1.0 V.
// - Undervoltage limit 75..85 percent setpoint in 5 percent steps, retry or latch.
// - Overvoltage, undervoltage, overtemperature, tracking turn stage off about 6 us late.
// - Overtemperature trips above 130 C; restart only at or below 120 C.
// - Tracking off by default; when enabled trips on more than 250 mV error during ramp-up.
// - Warning flag sets above 120 C, clears after 3 degree fall.
// - Warning flag follows its limit crossing about 6 us later.
// - Power-good high inside window 90 or 95 percent up to 110 percent.
// - Power-good changes about 6 us after a window edge is crossed.
`timescale 1ns/1ns
`include "pfm_regs.svh"
module pfm_fault_manager #(
  parameter int RETRY_CYC = `PFM_RETRY_CYC,
  parameter int FILTER_CYC = `PFM_FILTER_CYC,
  parameter logic [15:0] SETPOINT_RST = `PFM_SETPOINT_RST,
  parameter logic [15:0] RATED_RST = `PFM_RATED_RST
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire pfm_pkg::pfm_bus_req_t i_bus,
  output logic [15:0] o_rdata,
  input wire pfm_pkg::pfm_meas_t i_meas,
  input wire logic i_enable_pin,
  output logic o_stage_on,
  output logic o_output_in_window_pin,
  output logic o_warn,
  output pfm_pkg::pfm_fault_t o_fault
);
  import pfm_pkg::*;

  localparam int RCW = $clog2(RETRY_CYC + 1);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] scale(input logic [15:0] v, input logic [7:0] pct);
    scale = 32'(v) * 32'(pct);
  endfunction

  function automatic logic [7:0] pct_step(input logic [7:0] base, input logic [7:0] inc,
                                          input logic [3:0] step, input logic [3:0] max_step);
    logic [3:0] s;
    s = (step > max_step) ? max_step : step;
    pct_step = 8'(base + 8'(inc * {4'h0, s}));
  endfunction

  // ==========================================================
  // Registers
  logic [15:0] ctrl_reg;
  logic [15:0] limits_reg;
  logic [15:0] setpoint_reg;
  logic [15:0] rated_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rd_value;
  pfm_fault_t fault_reg;
  pfm_fault_t fault_clr;
  logic wr_ctrl;
  logic wr_limits;
  logic wr_status;
  logic wr_setpoint;
  logic wr_rated;

  assign wr_ctrl = i_bus.wr && (i_bus.addr == `PFM_OFF_CTRL);
  assign wr_limits = i_bus.wr && (i_bus.addr == `PFM_OFF_LIMITS);
  assign wr_status = i_bus.wr && (i_bus.addr == `PFM_OFF_STATUS);
  assign wr_setpoint = i_bus.wr && (i_bus.addr == `PFM_OFF_SETPOINT);
  assign wr_rated = i_bus.wr && (i_bus.addr == `PFM_OFF_RATED);
  assign fault_clr = wr_status ? pfm_fault_t'(i_bus.wdata[4:0]) : pfm_fault_t'(5'h00);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg <= `PFM_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= {9'h000, i_bus.wdata[6:0]};
    end
  end

  // Unused step codes are clamped when the limit is computed, not here
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      limits_reg <= `PFM_LIMITS_RST;
    end else if (wr_limits) begin
      limits_reg <= {7'h00, i_bus.wdata[8:0]};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      setpoint_reg <= SETPOINT_RST;
    end else if (wr_setpoint) begin
      setpoint_reg <= i_bus.wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rated_reg <= RATED_RST;
    end else if (wr_rated) begin
      rated_reg <= i_bus.wdata;
    end
  end

  // ==========================================================
  // Settings decode
  logic sw_enable;
  logic trk_enable;
  pfm_fault_t latch_mode;
  logic [7:0] oc_pct;
  logic [7:0] ov_pct;
  logic [7:0] uv_pct;
  logic [7:0] pg_pct;
  logic pin_enable;
  logic enable;

  assign sw_enable = ctrl_reg[`PFM_CTRL_EN_BIT];
  assign trk_enable = ctrl_reg[`PFM_CTRL_TRK_EN_BIT];
  assign latch_mode = pfm_fault_t'(ctrl_reg[`PFM_CTRL_LATCH_LSB +: 5]);
  assign oc_pct = pct_step(`PFM_OC_BASE, `PFM_OC_INC, limits_reg[`PFM_LIM_OC_LSB +: 4],
                           `PFM_OC_MAXSTEP);
  assign ov_pct = pct_step(`PFM_OV_BASE, `PFM_OV_INC, {2'h0, limits_reg[`PFM_LIM_OV_LSB +: 2]},
                           `PFM_OV_MAXSTEP);
  assign uv_pct = pct_step(`PFM_UV_BASE, `PFM_UV_INC, {2'h0, limits_reg[`PFM_LIM_UV_LSB +: 2]},
                           `PFM_UV_MAXSTEP);
  assign pg_pct = pct_step(`PFM_PG_LO_BASE, `PFM_PG_INC, {3'h0, limits_reg[`PFM_LIM_PG_BIT]},
                           `PFM_PG_MAXSTEP);

  pfm_sync3 u_enable_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_enable_pin),
    .o_level(pin_enable)
  );

  assign enable = sw_enable && pin_enable;

  // ==========================================================
  // Limit comparisons, percentage ones scaled by one hundred to avoid division
  logic [31:0] v100;
  logic [31:0] i100;
  logic [31:0] ov_pct_level;
  logic [31:0] ov_floor;
  logic [31:0] ov_level;
  logic [15:0] trk_err;
  logic oc_raw;
  logic ov_raw;
  logic uv_raw;
  logic ot_raw;
  logic trk_raw;
  logic pg_raw;
  logic ot_cool;
  logic warn_level_reg;

  assign v100 = scale(i_meas.vout_mv, `PFM_PCT_FULL);
  assign i100 = scale(i_meas.iout_ma, `PFM_PCT_FULL);
  assign ov_pct_level = scale(setpoint_reg, ov_pct);
  assign ov_floor = scale(`PFM_OV_FLOOR_MV, `PFM_PCT_FULL);
  // Low setpoints would otherwise put the trip level into normal ripple
  assign ov_level = (ov_pct_level > ov_floor) ? ov_pct_level : ov_floor;
  assign trk_err = (i_meas.vout_mv > i_meas.ramp_ref_mv) ?
                   16'(i_meas.vout_mv - i_meas.ramp_ref_mv) :
                   16'(i_meas.ramp_ref_mv - i_meas.vout_mv);

  assign oc_raw = i100 > scale(rated_reg, oc_pct);
  assign ov_raw = v100 > ov_level;
  // Undervoltage is masked during the ramp, where the output is legitimately low
  assign uv_raw = (v100 < scale(setpoint_reg, uv_pct)) && !i_meas.ramping;
  assign ot_raw = i_meas.temp_c > `PFM_OT_TRIP_C;
  assign ot_cool = i_meas.temp_c <= `PFM_OT_RESTART_C;
  assign trk_raw = trk_enable && i_meas.ramping && (trk_err > `PFM_TRK_LIMIT_MV);
  assign pg_raw = (v100 >= scale(setpoint_reg, pg_pct)) &&
                  (v100 <= scale(setpoint_reg, `PFM_PG_HI_PCT));

  // Warning with hysteresis ahead of the delay filter; the set wins
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      warn_level_reg <= 1'b0;
    end else if (i_meas.temp_c > `PFM_WARN_C) begin
      warn_level_reg <= 1'b1;
    end else if (i_meas.temp_c <= (`PFM_WARN_C - `PFM_WARN_HYST_C)) begin
      warn_level_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Delay qualification; overcurrent bypasses it to act at once
  logic [5:0] filt_q;
  logic ov_q;
  logic uv_q;
  logic ot_q;
  logic trk_q;

  pfm_delay_filter #(
    .W(6),
    .N(FILTER_CYC)
  ) u_filter (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_raw({pg_raw, warn_level_reg, trk_raw, ot_raw, uv_raw, ov_raw}),
    .o_q(filt_q)
  );

  assign ov_q = filt_q[0];
  assign uv_q = filt_q[1];
  assign ot_q = filt_q[2];
  assign trk_q = filt_q[3];
  assign o_warn = filt_q[4];
  assign o_output_in_window_pin = filt_q[5];

  // ==========================================================
  // Shutdown sequencing
  pfm_state_t state_reg;
  pfm_state_t state_next;
  pfm_fault_t trip;
  logic run;
  logic any_trip;
  logic latch_sel;
  logic ot_hold_reg;
  logic [RCW-1:0] retry_cnt_reg;
  logic retry_done;

  assign run = state_reg == PFM_ST_RUN;
  assign trip = run ? pfm_fault_t'({trk_q, ot_q, uv_q, ov_q, oc_raw}) : pfm_fault_t'(5'h00);
  assign any_trip = |trip;
  assign latch_sel = |(trip & latch_mode);
  assign retry_done = retry_cnt_reg == '0;
  assign o_stage_on = run;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PFM_ST_OFF: begin
        if (enable && !ot_hold_reg) begin
          state_next = PFM_ST_RUN;
        end
      end
      PFM_ST_RUN: begin
        if (any_trip) begin
          state_next = latch_sel ? PFM_ST_LATCH : PFM_ST_RETRY;
        end else if (!enable) begin
          state_next = PFM_ST_OFF;
        end
      end
      PFM_ST_RETRY: begin
        if (retry_done && !enable) begin
          state_next = PFM_ST_OFF;
        end else if (retry_done && !ot_hold_reg) begin
          state_next = PFM_ST_RUN;
        end
      end
      PFM_ST_LATCH: begin
        if (!enable) begin
          state_next = PFM_ST_OFF;
        end
      end
      default: begin
        state_next = PFM_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= PFM_ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      retry_cnt_reg <= '0;
    end else if (run && any_trip) begin
      retry_cnt_reg <= RCW'(RETRY_CYC - 1);
    end else if ((state_reg == PFM_ST_RETRY) && !retry_done) begin
      retry_cnt_reg <= retry_cnt_reg - RCW'(1);
    end
  end

  // Restart block after a thermal trip; a new trip wins over cooling
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ot_hold_reg <= 1'b0;
    end else if (trip.ot) begin
      ot_hold_reg <= 1'b1;
    end else if (ot_cool) begin
      ot_hold_reg <= 1'b0;
    end
  end

  // Sticky cause flags, write one to clear; a new trip wins over the clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_reg <= '0;
    end else begin
      fault_reg <= (fault_reg & ~fault_clr) | trip;
    end
  end

  assign o_fault = fault_reg;

  // ==========================================================
  // Read port, data valid only in the cycle after the strobe
  always_comb begin
    rd_value = 16'h0000;
    unique case (i_bus.addr)
      `PFM_OFF_CTRL: rd_value = ctrl_reg;
      `PFM_OFF_LIMITS: rd_value = limits_reg;
      `PFM_OFF_STATUS: begin
        rd_value[4:0] = fault_reg;
        rd_value[`PFM_ST_WARN_BIT] = o_warn;
        rd_value[`PFM_ST_PG_BIT] = o_output_in_window_pin;
        rd_value[`PFM_ST_ON_BIT] = run;
        rd_value[`PFM_ST_OTHOLD_BIT] = ot_hold_reg;
        rd_value[`PFM_ST_LATCH_BIT] = state_reg == PFM_ST_LATCH;
      end
      `PFM_OFF_SETPOINT: rd_value = setpoint_reg;
      `PFM_OFF_RATED: rd_value = rated_reg;
      default: rd_value = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= i_bus.rd ? rd_value : 16'h0000;
    end
  end

  assign o_rdata = rdata_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  chk_oc_trip_off: assert property (run && oc_raw |=> !o_stage_on && fault_reg.oc)
    else $error("overcurrent did not stop the stage");
  chk_ov_level: assert property (ov_raw |-> v100 > scale(setpoint_reg, ov_pct))
    else $error("overvoltage raised below the programmed level");
  chk_ov_floor: assert property (ov_raw |-> i_meas.vout_mv > `PFM_OV_FLOOR_MV)
    else $error("overvoltage raised below the one volt floor");
  chk_uv_level: assert property (uv_raw |-> v100 < scale(setpoint_reg, uv_pct))
    else $error("undervoltage raised above the programmed level");
  chk_trip_latency: assert property (run && $rose(ov_q) |=> !o_stage_on ##1 !o_stage_on)
    else $error("qualified overvoltage did not stop the stage");
  chk_ot_restart: assert property (ot_hold_reg && !ot_cool |=> !o_stage_on)
    else $error("restart while still hot after a thermal trip");
  chk_trk_window: assert property (trk_raw |-> trk_enable && i_meas.ramping)
    else $error("tracking fault outside an enabled ramp");
  chk_warn_hyst: assert property (warn_level_reg && i_meas.temp_c > 10'sh075 |=> warn_level_reg)
    else $error("warning dropped inside the hysteresis band");
  chk_pg_window: assert property (pg_raw |-> v100 <= scale(setpoint_reg, `PFM_PG_HI_PCT))
    else $error("power good raised above the upper edge");
  chk_retry_restart: assert property (
    state_reg == PFM_ST_RETRY && retry_done && enable && !ot_hold_reg |=> o_stage_on)
    else $error("no restart at the end of the retry period");
  chk_latch_hold: assert property (state_reg == PFM_ST_LATCH && enable |=> !o_stage_on)
    else $error("latched fault restarted without re-enable");
  chk_retry_load: assert property (run && any_trip && !latch_sel |=>
    state_reg == PFM_ST_RETRY && retry_cnt_reg == RCW'(RETRY_CYC - 1))
    else $error("retry period not loaded on a trip");
  chk_fault_flag: assert property (trip.ov |=> fault_reg.ov)
    else $error("overvoltage cause flag not set");

  cov_retry_cycle: cover property (state_reg == PFM_ST_RETRY ##1 state_reg == PFM_ST_RUN);
  cov_latched: cover property (run ##1 state_reg == PFM_ST_LATCH);
  cov_warn_rise: cover property ($rose(o_warn));
  cov_pg_rise: cover property ($rose(o_output_in_window_pin));
endmodule

/* dv/pfm_plant_model.sv */
`timescale 1ns/1ns
// ==========================================================
// Converter output seen by the measurement path
module pfm_plant_model (
  input wire logic i_stage_on,
  input wire pfm_pkg::pfm_meas_t i_nom,
  output pfm_pkg::pfm_meas_t o_meas
);
  import pfm_pkg::*;
  // Output collapses while the stage is off; flagged as ramping so a restart starts clean
  always_comb begin
    o_meas = i_nom;
    if (!i_stage_on) begin
      o_meas.vout_mv = 16'h0000;
      o_meas.iout_ma = 16'h0000;
      o_meas.ramping = 1'b1;
    end
  end
endmodule

/* dv/pol_fault_protection_manager_bench.sv */
`timescale 1ns/1ns
`include "pfm_regs.svh"
// ==========================================================
// Bench top
module pol_fault_protection_manager_bench;
  import pfm_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  pfm_bus_req_t bus = '0;
  pfm_meas_t nom = '0;
  pfm_meas_t meas;
  logic en_pin = 1'b0;
  logic [15:0] rdata;
  logic stage_on;
  logic pg;
  logic warn;
  pfm_fault_t fault;
  int error_cnt = 0;
  int n_tests = 0;

  always #2 i_clk = ~i_clk;

  // Short counts keep the run brief; expectations use the same figures
  pfm_fault_manager #(.RETRY_CYC(50), .FILTER_CYC(8)) uut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(rdata), .i_meas(meas),
    .i_enable_pin(en_pin), .o_stage_on(stage_on), .o_output_in_window_pin(pg),
    .o_warn(warn), .o_fault(fault)
  );
  pfm_plant_model plant (.i_stage_on(stage_on), .i_nom(nom), .o_meas(meas));

  // ==========================================================
  // Helpers
  task print_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    bus.wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus.rd <= 1'b0;
    #1;
    chk(nm, rdata, exp);
  endtask
  task sv(input logic [15:0] v, input logic [15:0] c, input logic signed [9:0] t);
    @(posedge i_clk);
    nom.vout_mv <= v;
    nom.iout_ma <= c;
    nom.temp_c <= t;
    #1;
  endtask
  // Cycles from the measurement change until the stage drops, then the cause flags
  task trip(input int b, input int lo, input int hi);
    int n;
    n = 0;
    while (stage_on === 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk("trip delay", 16'(n >= lo && n <= hi), 16'h0001);
    chk("fault flags", {11'h000, fault}, 16'(1 << b));
  endtask
  task wait_on(input int lo, input int hi);
    int n;
    n = 0;
    while (stage_on !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk("restart time", 16'(n >= lo && n <= hi), 16'h0001);
  endtask

  // ==========================================================
  // Tests
  initial begin
    sv(16'h09C4, 16'h0000, 10'sh019);
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(`PFM_OFF_CTRL, 16'h0001, "ctrl reset");
    rd(`PFM_OFF_LIMITS, 16'h002A, "limits reset");
    rd(`PFM_OFF_SETPOINT, 16'h09C4, "setpoint reset");
    rd(`PFM_OFF_RATED, 16'h2710, "rated reset");
    rd(8'h14, 16'h0000, "unmapped read");
    wr(8'h14, 16'hFFFF);
    en_pin <= 1'b1;
    wait_on(2, 20);
    cyc(12);
    rd(`PFM_OFF_STATUS, 16'h00C0, "status running");
    // Tracking stays off by default even while ramping far from reference
    nom.ramping <= 1'b1;
    cyc(20);
    chk("tracking default", {15'h0, stage_on}, 16'h0001);
    nom.ramping <= 1'b0;
    // Overcurrent limit over every step, boundary then one above, then retry
    for (int s = 0; s < 11; s++) begin
      wr(`PFM_OFF_LIMITS, 16'(16'h0020 | s));
      sv(16'h09C4, 16'(100 * (50 + 10 * s)), 10'sh019);
      cyc(3);
      chk("oc at limit", {15'h0, stage_on}, 16'h0001);
      sv(16'h09C4, 16'(100 * (50 + 10 * s) + 1), 10'sh019);
      trip(0, 1, 1);
      sv(16'h09C4, 16'h0000, 10'sh019);
      wait_on(44, 56);
      wr(`PFM_OFF_STATUS, 16'h001F);
    end
    // Power good needs its qualifying delay after the last restart
    cyc(12);
    rd(`PFM_OFF_STATUS, 16'h00C0, "status after clear");
    // Overvoltage at default 130 percent
    sv(16'h0CB2, 16'h0000, 10'sh019);
    cyc(12);
    chk("ov at limit", {15'h0, stage_on}, 16'h0001);
    sv(16'h0CB3, 16'h0000, 10'sh019);
    trip(1, 8, 11);
    sv(16'h09C4, 16'h0000, 10'sh019);
    wait_on(35, 56);
    wr(`PFM_OFF_STATUS, 16'h001F);
    // Low setpoint at 110 percent: trip level held at the 1.0 V floor
    sv(16'h0384, 16'h0000, 10'sh019);
    wr(`PFM_OFF_SETPOINT, 16'h01F4);
    wr(`PFM_OFF_LIMITS, 16'h000A);
    cyc(20);
    chk("ov floor", {15'h0, stage_on}, 16'h0001);
    sv(16'h03E9, 16'h0000, 10'sh019);
    trip(1, 8, 11);
    wr(`PFM_OFF_SETPOINT, 16'h09C4);
    // Back to 130 percent so the window tests above 110 percent do not trip
    wr(`PFM_OFF_LIMITS, 16'h002A);
    sv(16'h09C4, 16'h0000, 10'sh019);
    wait_on(25, 56);
    wr(`PFM_OFF_STATUS, 16'h001F);
    // Undervoltage in latching mode, released by dropping enable
    wr(`PFM_OFF_CTRL, 16'h0011);
    sv(16'h074E, 16'h0000, 10'sh019);
    trip(2, 8, 11);
    cyc(80);
    chk("latched off", {15'h0, stage_on}, 16'h0000);
    rd(`PFM_OFF_STATUS, 16'h0204, "status latched");
    sv(16'h09C4, 16'h0000, 10'sh019);
    wr(`PFM_OFF_CTRL, 16'h0010);
    wr(`PFM_OFF_CTRL, 16'h0011);
    wait_on(1, 20);
    wr(`PFM_OFF_STATUS, 16'h001F);
    wr(`PFM_OFF_CTRL, 16'h0001);
    // Power-good window edges and delay
    sv(16'h08CA, 16'h0000, 10'sh019);
    cyc(12);
    chk("pg low edge", {15'h0, pg}, 16'h0001);
    sv(16'h08C9, 16'h0000, 10'sh019);
    cyc(5);
    chk("pg delay", {15'h0, pg}, 16'h0001);
    cyc(7);
    chk("pg below", {15'h0, pg}, 16'h0000);
    sv(16'h0ABE, 16'h0000, 10'sh019);
    cyc(12);
    chk("pg high edge", {15'h0, pg}, 16'h0001);
    sv(16'h0ABF, 16'h0000, 10'sh019);
    cyc(12);
    chk("pg above", {15'h0, pg}, 16'h0000);
    wr(`PFM_OFF_LIMITS, 16'h012A);
    sv(16'h0943, 16'h0000, 10'sh019);
    cyc(12);
    chk("pg 95 percent", {15'h0, pg}, 16'h0000);
    wr(`PFM_OFF_LIMITS, 16'h002A);
    sv(16'h09C4, 16'h0000, 10'sh019);
    // Warning with hysteresis
    sv(16'h09C4, 16'h0000, 10'sh079);
    cyc(4);
    chk("warn delay", {15'h0, warn}, 16'h0000);
    cyc(8);
    chk("warn set", {15'h0, warn}, 16'h0001);
    sv(16'h09C4, 16'h0000, 10'sh076);
    cyc(12);
    chk("warn hold", {15'h0, warn}, 16'h0001);
    sv(16'h09C4, 16'h0000, 10'sh075);
    cyc(12);
    chk("warn clear", {15'h0, warn}, 16'h0000);
    // Overtemperature trip, restart held until 120 C
    sv(16'h09C4, 16'h0000, 10'sh082);
    cyc(12);
    chk("ot at limit", {15'h0, stage_on}, 16'h0001);
    sv(16'h09C4, 16'h0000, 10'sh083);
    trip(3, 8, 11);
    sv(16'h09C4, 16'h0000, 10'sh07D);
    cyc(70);
    wr(`PFM_OFF_STATUS, 16'h001F);
    rd(`PFM_OFF_STATUS, 16'h0120, "status thermal hold");
    sv(16'h09C4, 16'h0000, 10'sh078);
    wait_on(1, 20);
    sv(16'h09C4, 16'h0000, 10'sh019);
    // Tracking enabled: 250 mV error allowed, one more trips
    wr(`PFM_OFF_CTRL, 16'h0003);
    nom.ramp_ref_mv <= 16'h08CA;
    nom.ramping <= 1'b1;
    cyc(12);
    chk("track at limit", {15'h0, stage_on}, 16'h0001);
    sv(16'h09C5, 16'h0000, 10'sh019);
    trip(4, 8, 11);
    wr(`PFM_OFF_CTRL, 16'h0001);
    nom.ramping <= 1'b0;
    sv(16'h09C4, 16'h0000, 10'sh019);
    wait_on(1, 56);
    print_verdict();
  end

  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
endmodule
